// file: dv/sensor_host_register_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// self-checking bench: register traffic over spi and i2c
`define CHK(n, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) begin \
      err_total++; \
      $display("CHECK FAILED %s exp %h got %h", n, e, g); \
    end \
  end
module sensor_host_register_port_tb_top;
  import shp_pkg::*;
  logic            mclk, rst_n, addr_sel, meas_busy, otp_busy, a;
  wire logic       sck, csb_n, line, sdo_out, sdo_oe, sdi_out, sdi_oe;
  wire logic       sda_out, sda_oe, hs_mode, three_wire_select;
  wire logic [2:0] smoothing_filter_depth;
  wire logic       smoothing_filter_reinit, soft_reset_pulse;
  int              checks, err_total, reinit_cnt, soft_cnt, n;
  logic [15:0]     q;
  logic [23:0]     r;
  logic [7:0]      b;

  shp_port shp_port_i (
    .mclk(mclk), .rst_n(rst_n), .sck(sck), .csb_n(csb_n),
    .sdi_in(line), .scl_in(sck), .sda_in(line), .addr_sel(addr_sel),
    .meas_busy(meas_busy), .otp_busy(otp_busy), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .sdi_out(sdi_out), .sdi_oe(sdi_oe),
    .sda_out(sda_out), .sda_oe(sda_oe), .hs_mode(hs_mode),
    .three_wire_select(three_wire_select),
    .smoothing_filter_depth(smoothing_filter_depth),
    .smoothing_filter_reinit(smoothing_filter_reinit),
    .soft_reset_pulse(soft_reset_pulse)
  );
  shp_host shp_host_i (
    .sck(sck), .csb_n(csb_n), .line(line), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .sdi_out(sdi_out), .sdi_oe(sdi_oe),
    .sda_oe(sda_oe)
  );

  // system clock
  always #10 mclk = ~mclk;

  // count side effect pulses
  always @(posedge mclk) begin
    reinit_cnt <= reinit_cnt + int'(smoothing_filter_reinit === 1'b1);
    soft_cnt   <= soft_cnt + int'(soft_reset_pulse === 1'b1);
  end

  task automatic summarize();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic spi_wr(input logic [6:0] ad, input logic [7:0] d);
    logic [7:0] k;
    shp_host_i.spi_begin();
    shp_host_i.shift({1'b0, ad}, 80, k);
    shp_host_i.shift(d, 80, k);
    shp_host_i.spi_end();
  endtask

  // two byte burst read
  task automatic spi_rd(input logic [6:0] ad, output logic [15:0] v);
    logic [7:0] k;
    shp_host_i.spi_begin();
    shp_host_i.shift({1'b1, ad}, 80, k);
    shp_host_i.shift(8'hFF, 80, v[15:8]);
    shp_host_i.shift(8'hFF, 80, v[7:0]);
    shp_host_i.spi_end();
  endtask

  task automatic i2c_wr(input logic [6:0] dv, input logic [7:0] ra,
                        input logic [7:0] d);
    logic [23:0] s;
    logic [7:0]  k;
    logic        ak;
    s = {dv, 1'b0, ra, d};
    shp_host_i.i2c_start();
    for (int i = 0; i < 3; i++) begin
      shp_host_i.i2c_byte(s[23:16], 1'b1, k, ak);
      `CHK("write ack", 1'b0, ak)
      s = s << 8;
    end
    shp_host_i.i2c_stop();
  endtask

  // three byte read after pointer write and restart
  task automatic i2c_rd(input logic [6:0] dv, input logic [7:0] ra,
                        output logic [23:0] v);
    logic [7:0] k;
    logic       ak;
    shp_host_i.i2c_start();
    shp_host_i.i2c_byte({dv, 1'b0}, 1'b1, k, ak);
    shp_host_i.i2c_byte(ra, 1'b1, k, ak);
    shp_host_i.i2c_start();
    shp_host_i.i2c_byte({dv, 1'b1}, 1'b1, k, ak);
    `CHK("read ack", 1'b0, ak)
    for (int i = 0; i < 3; i++) begin
      shp_host_i.i2c_byte(8'hFF, i == 2, k, ak);
      v = {v[15:0], k};
    end
    shp_host_i.i2c_stop();
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge mclk);
    err_total++;
    summarize();
  end

  // main sequence
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    addr_sel = 1'b1;
    meas_busy = 1'b0;
    otp_busy = 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    spi_rd(7'h71, q);
    `CHK("filter preamble", 16'h0001, q)
    spi_rd(7'h51, q);
    `CHK("identity", {PART_ID_DEFAULT, 8'h00}, q)
    spi_rd(7'h60, q);
    `CHK("reset reg read", 16'h0000, q)
    spi_rd(7'h7F, q);
    `CHK("address top", 16'hFFFF, q)
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      meas_busy <= i[1];
      otp_busy  <= i[0];
      spi_rd(7'h73, q);
      `CHK("status", {4'h0, i[1], 2'h0, i[0], 8'h00}, q)
    end
    for (int v = 0; v < 8; v++) begin
      n = reinit_cnt;
      spi_wr(7'h71, {5'h00, v[2:0]});
      `CHK("depth", (v > 5) ? 3'h5 : v[2:0], smoothing_filter_depth)
      `CHK("reinit", n + 1, reinit_cnt)
      spi_rd(7'h71, q);
      `CHK("filter read", {5'h00, v[2:0]}, q[15:8])
    end
    shp_host_i.spi_begin();
    shp_host_i.shift(8'h71, 80, b);
    shp_host_i.shift(8'h02, 80, b);
    shp_host_i.shift(8'h72, 80, b);
    shp_host_i.shift(8'h03, 80, b);
    shp_host_i.spi_end();
    spi_rd(7'h71, q);
    `CHK("paired writes", 16'h0203, q)
    n = soft_cnt;
    spi_wr(7'h60, 8'h55);
    spi_rd(7'h71, q);
    `CHK("wrong key", 16'h0203, q)
    spi_wr(7'h60, 8'hE6);
    spi_rd(7'h71, q);
    `CHK("right key", 16'h0001, q)
    `CHK("reset pulses", n + 1, soft_cnt)
    spi_wr(7'h75, 8'h01);
    `CHK("three wire", 1'b1, three_wire_select)
    shp_host_i.use_sdo = 1'b0;
    spi_rd(7'h71, q);
    `CHK("shared pin read", 16'h0001, q)
    spi_wr(7'h75, 8'h00);
    i2c_wr(7'h56, 8'hF2, 8'h05);
    i2c_rd(7'h56, 8'hF1, r);
    `CHK("i2c burst", 24'h00_0500, r)
    i2c_rd(7'h56, 8'hFE, r);
    `CHK("i2c top", 24'h00_FFFF, r)
    shp_host_i.i2c_start();
    shp_host_i.i2c_byte({7'h70, 1'b0}, 1'b1, b, a);
    `CHK("foreign address", 1'b1, a)
    shp_host_i.i2c_stop();
    @(posedge mclk);
    addr_sel <= 1'b0;
    #7;
    i2c_rd(7'h70, 8'hD1, r);
    `CHK("low address", {PART_ID_DEFAULT, 16'h0000}, r)
    shp_host_i.i2c_start();
    shp_host_i.i2c_byte(8'h0D, 1'b1, b, a);
    `CHK("code not acked", 1'b1, a)
    `CHK("code seen", 1'b1, hs_mode)
    shp_host_i.i2c_stop();
    `CHK("code cleared", 1'b0, hs_mode)
    summarize();
  end
endmodule
`default_nettype wire

// file: dv/shp_host.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// host model: spi and i2c master on one clock and one data wire
module shp_host (
  output var  logic sck,
  output var  logic csb_n,
  output wire logic line,
  input  wire logic sdo_out,
  input  wire logic sdo_oe,
  input  wire logic sdi_out,
  input  wire logic sdi_oe,
  input  wire logic sda_oe
);
  logic      host_d;
  logic      use_sdo;
  wire logic sdo_pin;

  // pulled up wires: device drive wins, else host level
  assign line    = sdi_oe ? sdi_out : (sda_oe ? 1'b0 : host_d);
  assign sdo_pin = sdo_oe ? sdo_out : 1'b1;

  // idle levels
  initial begin
    sck = 1'b0;
    csb_n = 1'b1;
    host_d = 1'b1;
    use_sdo = 1'b1;
  end

  // one byte msb first, data changes after each fall
  task automatic shift(input logic [7:0] b, input int h,
                       output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      host_d = b[i];
      #h;
      sck = 1'b1;
      q[i] = use_sdo ? sdo_pin : line;
      #h;
      sck = 1'b0;
    end
  endtask

  task automatic spi_begin();
    #7;
    sck = 1'b0;
    csb_n = 1'b0;
    #80;
  endtask

  task automatic spi_end();
    host_d = 1'b1;
    #80;
    csb_n = 1'b1;
    #160;
  endtask

  task automatic i2c_start();
    host_d = 1'b1;
    #160;
    sck = 1'b1;
    #160;
    host_d = 1'b0;
    #160;
    sck = 1'b0;
  endtask

  task automatic i2c_stop();
    host_d = 1'b0;
    #160;
    sck = 1'b1;
    #160;
    host_d = 1'b1;
    #160;
  endtask

  // byte plus ninth bit, m high is a master nack
  task automatic i2c_byte(input logic [7:0] b, input logic m,
                          output logic [7:0] q, output logic a);
    shift(b, 160, q);
    host_d = m;
    #160;
    sck = 1'b1;
    a = line;
    #160;
    sck = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/shp_port_assertions.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// port checker: side effect pulses, config values, serial enables
module shp_port_assertions (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       sck,
  input wire logic       csb_n,
  input wire logic       sdi_in,
  input wire logic       sdo_oe,
  input wire logic       sdi_oe,
  input wire logic       sda_out,
  input wire logic       three_wire_select,
  input wire logic [2:0] smoothing_filter_depth,
  input wire logic       smoothing_filter_reinit,
  input wire logic       soft_reset_pulse
);
  logic [2:0] cause_reg;

  // recent register side effects that may move the depth
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= 3'h0;
    end else begin
      cause_reg <= {cause_reg[1:0],
                    smoothing_filter_reinit | soft_reset_pulse};
    end
  end

  // filter depth and wiring mode back at reset values
  sequence s_cfg_home;
    smoothing_filter_depth == 3'h0 && !three_wire_select;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  // system clock domain
  reinit_pulse_a:
    assert property (@(posedge mclk) disable iff (!rst_n)
      smoothing_filter_reinit |=> !smoothing_filter_reinit)
    else $error("reinit pulse too long");
  reset_pulse_a:
    assert property (@(posedge mclk) disable iff (!rst_n)
      soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  depth_range_a:
    assert property (@(posedge mclk) disable iff (!rst_n)
      smoothing_filter_depth <= 3'h5)
    else $error("filter depth out of range");
  soft_restore_a:
    assert property (@(posedge mclk) disable iff (!rst_n)
      soft_reset_pulse |-> ##[1:3] s_cfg_home)
    else $error("config not restored by soft reset");
  depth_cause_a:
    assert property (@(posedge mclk) disable iff (!rst_n)
      $changed(smoothing_filter_depth) |-> smoothing_filter_reinit
        || soft_reset_pulse || cause_reg != 3'h0)
    else $error("depth moved without a write");
  spi_quiet_a:
    assert property (@(posedge mclk) disable iff (!rst_n)
      csb_n |-> !sdo_oe && !sdi_oe)
    else $error("serial output driven while deselected");
  sda_low_a:
    assert property (@(posedge mclk) disable iff (!rst_n) !sda_out)
    else $error("data pin driven high");

  ////////////////////////////////////////////////////////////////////////
  // serial clock domain
  three_wire_oe_a:
    assert property (@(posedge sck) disable iff (!rst_n)
      sdi_oe |-> three_wire_select)
    else $error("shared pin driven in four wire mode");
  four_wire_oe_a:
    assert property (@(posedge sck) disable iff (!rst_n)
      sdo_oe |-> !three_wire_select)
    else $error("output pin driven in three wire mode");
  read_start_a:
    assert property (@(posedge sck) disable iff (!rst_n)
      $rose(sdo_oe || sdi_oe) |-> $past(sdi_in, 8))
    else $error("read data without read control bit");
endmodule

bind shp_port shp_port_assertions shp_port_assertions_i (
  .mclk(mclk), .rst_n(rst_n), .sck(sck), .csb_n(csb_n),
  .sdi_in(sdi_in), .sdo_oe(sdo_oe), .sdi_oe(sdi_oe),
  .sda_out(sda_out), .three_wire_select(three_wire_select),
  .smoothing_filter_depth(smoothing_filter_depth),
  .smoothing_filter_reinit(smoothing_filter_reinit),
  .soft_reset_pulse(soft_reset_pulse)
);
`default_nettype wire

// file: verilog/shp_pkg.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////
// shared constants and carriers of the sensor host register port
package shp_pkg;

  // register addresses as seen over i2c
  localparam logic [7:0] ADDR_PART_ID   = 8'hD1;
  localparam logic [7:0] ADDR_SOFT_RST  = 8'hE0;
  localparam logic [7:0] ADDR_FILTER    = 8'hF1;
  localparam logic [7:0] ADDR_HS_SEL    = 8'hF2;
  localparam logic [7:0] ADDR_STATUS    = 8'hF3;
  localparam logic [7:0] ADDR_IO_SETUP  = 8'hF5;
  localparam logic [7:0] ADDR_LAST      = 8'hFF;
  // spi address page: i2c msb that spi replaces with the r/w bit
  localparam logic       SPI_PAGE_BIT   = 1'b1;
  localparam logic [6:0] SPI_ADDR_LAST  = 7'h7F;

  // reset values and keys
  localparam logic [7:0] SOFT_RESET_KEY = 8'hE6;
  localparam logic [2:0] HS_SEL_RESET   = 3'h1;
  localparam logic [2:0] FILTER_RESET   = 3'h0;
  localparam logic       IO_RESET       = 1'b0;
  localparam logic [2:0] FILTER_MAX     = 3'h5;
  // arbitrary neutral identity value
  localparam logic [7:0] PART_ID_DEFAULT = 8'hA7;

  // i2c slave addresses and high speed preamble prefix
  localparam logic [6:0] I2C_ADDR_HIGH  = 7'h56;
  localparam logic [6:0] I2C_ADDR_LOW   = 7'h70;
  localparam logic [4:0] HS_CODE_PREFIX = 5'h01;

  // status bit positions
  localparam int STAT_MEAS_BIT = 3;
  localparam int STAT_OTP_BIT  = 0;

  // configuration and status snapshot seen by both domains
  typedef struct packed {
    logic [2:0] filter;
    logic [2:0] hs_sel;
    logic       three_wire;
    logic       meas;
    logic       otp;
  } shp_cfg_t;

  // one register write: address and data
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } shp_wr_t;

endpackage
`default_nettype wire

// file: verilog/shp_port.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [RULE1] status bit 3 follows the measurement busy level from the core
// [RULE2] status bit 0 follows the calibration rom access level
// [RULE3] preamble field selects code 0x08 plus field, resets to 001
// [RULE4] filter field 0 off, 1..4 N=2..16, 5..7 all N=32, reset off
// [RULE5] every write to the filter register pulses a reinit
// [RULE6] writing E6h to the soft reset register resets, other values nothing
// [RULE7] identity register reads a fixed code
// [RULE8] i2c slave address 56h with select pin high, 70h when low
// [RULE9] address byte lsb zero means write, one means read
// [RULE10] i2c write carries register address and data pairs until stop
// [RULE11] host sets the read pointer by a write, then restarts to read
// [RULE12] i2c read auto increments until nack, sticking at 0xFF
// [RULE13] spi write: control 0 plus address, then data, pairs repeat
// [RULE14] spi read data leaves on sdo, or sdi in three wire mode
// [RULE15] spi read address increments per byte until chip select rises; the code holds it at 7Fh
// [RULE16] i2c oversampled logic serves 100k, 400k and 3.4M bit rates
// [RULE17] io setup bit 0 selects four wire (0) or three wire (1)
// [RULE18] spi address is the i2c address with msb replaced by r/w bit
// [RULE19] reserved bits are not stored and read back as zero
module shp_port
  import shp_pkg::*;
#(
  parameter logic [7:0] PART_ID = shp_pkg::PART_ID_DEFAULT
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       sck,
  input  wire logic       csb_n,
  input  wire logic       sdi_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       addr_sel,
  input  wire logic       meas_busy,
  input  wire logic       otp_busy,
  output var  logic       sdo_out,
  output var  logic       sdo_oe,
  output var  logic       sdi_out,
  output var  logic       sdi_oe,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  output var  logic       hs_mode,
  output var  logic       three_wire_select,
  output var  logic [2:0] smoothing_filter_depth,
  output var  logic       smoothing_filter_reinit,
  output var  logic       soft_reset_pulse
);
  import shp_pkg::*;

  typedef enum logic [5:0] {
    I_IDLE = 6'b00_0001,
    I_ADDR = 6'b00_0010,
    I_ACK  = 6'b00_0100,
    I_RX   = 6'b00_1000,
    I_TX   = 6'b01_0000,
    I_MACK = 6'b10_0000
  } shp_i2c_t;

  // read multiplexer shared by both domains
  function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                        input shp_cfg_t   c);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      // [RULE1] [RULE2] status readback
      ADDR_STATUS: begin
        r[STAT_MEAS_BIT] = c.meas;
        r[STAT_OTP_BIT]  = c.otp;
      end
      // [RULE19] reserved bits zero
      ADDR_HS_SEL:   r = {5'h00, c.hs_sel};
      ADDR_FILTER:   r = {5'h00, c.filter};
      ADDR_IO_SETUP: r = {7'h00, c.three_wire};
      // [RULE7] fixed identity
      ADDR_PART_ID:  r = PART_ID;
      // [RULE12] end of map reads all ones
      ADDR_LAST:     r = ADDR_LAST;
      default:       r = 8'h00;
    endcase
    return r;
  endfunction

  logic [2:0] filter_reg;
  logic [2:0] hs_sel_reg;
  logic       meas_reg;
  logic       otp_reg;
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic [1:0] csb_sync;
  logic [1:0] asel_sync;
  logic [2:0] tgl_sync;
  shp_cfg_t   cfg_m;
  shp_wr_t    spi_pair_reg;
  logic       spi_tgl_reg;
  shp_wr_t    i2c_pair_reg;
  logic       i2c_wr_reg;
  logic       wr_ev;
  shp_wr_t    wr_now;
  shp_i2c_t   i_state_reg;
  logic [7:0] i_sh_reg;
  logic [3:0] i_cnt_reg;
  logic       i_rd_reg;
  logic       i_exp_data_reg;
  logic       i_ack_on_reg;
  logic [7:0] i_ptr_reg;
  logic [7:0] i_byte;
  logic [7:0] i_rd_data;
  logic [6:0] my_addr;
  logic       scl_rise, scl_fall, i_start, i_stop, i2c_on;

  assign cfg_m = '{filter: filter_reg, hs_sel: hs_sel_reg,
                   three_wire: three_wire_select, meas: meas_reg,
                   otp: otp_reg};

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage read only by the second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync  <= 3'b111;
      sda_sync  <= 3'b111;
      csb_sync  <= 2'b11;
      asel_sync <= 2'b00;
      tgl_sync  <= 3'b000;
    end else begin
      scl_sync  <= {scl_sync[1:0], scl_in};
      sda_sync  <= {sda_sync[1:0], sda_in};
      csb_sync  <= {csb_sync[0], csb_n};
      asel_sync <= {asel_sync[0], addr_sel};
      tgl_sync  <= {tgl_sync[1:0], spi_tgl_reg};
    end
  end

  // bus condition detection on synchronised levels
  assign i2c_on   = csb_sync[1];
  assign scl_rise = scl_sync[1] & ~scl_sync[2];
  assign scl_fall = ~scl_sync[1] & scl_sync[2];
  assign i_start  = scl_sync[1] & scl_sync[2] & sda_sync[2] & ~sda_sync[1];
  assign i_stop   = scl_sync[1] & scl_sync[2] & ~sda_sync[2] & sda_sync[1];
  assign i_byte   = {i_sh_reg[6:0], sda_sync[1]};
  assign i_rd_data = rd_mux(i_ptr_reg, cfg_m);
  // [RULE8] pin selected slave address
  assign my_addr  = asel_sync[1] ? I2C_ADDR_HIGH : I2C_ADDR_LOW;

  // write source select; spi pair is stable once its toggle is seen
  assign wr_ev  = i2c_wr_reg | (tgl_sync[1] ^ tgl_sync[2]);
  assign wr_now = i2c_wr_reg ? i2c_pair_reg : spi_pair_reg;

  ////////////////////////////////////////////////////////////////////
  // configuration registers and their write side effects
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      filter_reg              <= FILTER_RESET;
      hs_sel_reg              <= HS_SEL_RESET;
      three_wire_select       <= IO_RESET;
      smoothing_filter_reinit <= 1'b0;
      soft_reset_pulse        <= 1'b0;
    end else begin
      smoothing_filter_reinit <= 1'b0;
      soft_reset_pulse        <= 1'b0;
      if (wr_ev) begin
        unique case (wr_now.addr)
          // [RULE4] [RULE5] filter write reinitialises
          ADDR_FILTER: begin
            filter_reg              <= wr_now.data[2:0];
            smoothing_filter_reinit <= 1'b1;
          end
          // [RULE3] preamble select
          ADDR_HS_SEL:   hs_sel_reg <= wr_now.data[2:0];
          // [RULE17] spi wiring select
          ADDR_IO_SETUP: three_wire_select <= wr_now.data[0];
          // [RULE6] keyed soft reset
          ADDR_SOFT_RST: begin
            if (wr_now.data == SOFT_RESET_KEY) begin
              filter_reg        <= FILTER_RESET;
              hs_sel_reg        <= HS_SEL_RESET;
              three_wire_select <= IO_RESET;
              soft_reset_pulse  <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // [RULE4] decoded filter depth, codes above five saturate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      smoothing_filter_depth <= FILTER_RESET;
    end else begin
      smoothing_filter_depth <= (filter_reg > FILTER_MAX) ? FILTER_MAX
                                                          : filter_reg;
    end
  end

  // [RULE1] [RULE2] status flags track the core levels
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meas_reg <= 1'b0;
      otp_reg  <= 1'b0;
      sda_out  <= 1'b0;
    end else begin
      meas_reg <= meas_busy;
      otp_reg  <= otp_busy;
      sda_out  <= 1'b0;            // open drain: only ever pulls low
    end
  end

  ////////////////////////////////////////////////////////////////////
  // [RULE16] i2c slave oversampled on mclk
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      i_state_reg    <= I_IDLE;
      i_sh_reg       <= 8'h00;
      i_cnt_reg      <= 4'h0;
      i_rd_reg       <= 1'b0;
      i_exp_data_reg <= 1'b0;
      i_ack_on_reg   <= 1'b0;
      i_ptr_reg      <= 8'h00;
      i2c_wr_reg     <= 1'b0;
      i2c_pair_reg   <= '0;
      sda_oe         <= 1'b0;
      hs_mode        <= 1'b0;
    end else begin
      i2c_wr_reg <= 1'b0;
      if (i_stop || !i2c_on) begin
        i_state_reg  <= I_IDLE;
        sda_oe       <= 1'b0;
        i_ack_on_reg <= 1'b0;
        hs_mode      <= 1'b0;
      end else if (i_start) begin
        i_state_reg    <= I_ADDR;
        i_cnt_reg      <= 4'h0;
        i_exp_data_reg <= 1'b0;
        i_ack_on_reg   <= 1'b0;
        sda_oe         <= 1'b0;
      end else begin
        unique case (i_state_reg)
          I_IDLE: ;
          I_ADDR: begin
            if (scl_rise) begin
              i_sh_reg  <= i_byte;
              i_cnt_reg <= i_cnt_reg + 4'h1;
              if (i_cnt_reg == 4'h7) begin
                // [RULE8] [RULE9] address match and direction
                if (i_byte[7:1] == my_addr) begin
                  i_rd_reg    <= i_byte[0];
                  i_state_reg <= I_ACK;
                end else begin
                  // [RULE3] master code is never acknowledged
                  if (i_byte == {HS_CODE_PREFIX, hs_sel_reg})
                    hs_mode <= 1'b1;
                  i_state_reg <= I_IDLE;
                end
              end
            end
          end
          I_ACK: begin
            if (scl_fall) begin
              if (!i_ack_on_reg) begin
                i_ack_on_reg <= 1'b1;
                sda_oe       <= 1'b1;
              end else if (i_rd_reg) begin
                i_ack_on_reg <= 1'b0;
                i_state_reg  <= I_TX;
                i_sh_reg     <= i_rd_data;
                sda_oe       <= ~i_rd_data[7];
                i_cnt_reg    <= 4'h1;
              end else begin
                i_ack_on_reg <= 1'b0;
                i_state_reg  <= I_RX;
                sda_oe       <= 1'b0;
                i_cnt_reg    <= 4'h0;
              end
            end
          end
          I_RX: begin
            if (scl_rise) begin
              i_sh_reg  <= i_byte;
              i_cnt_reg <= i_cnt_reg + 4'h1;
              if (i_cnt_reg == 4'h7) begin
                // [RULE10] [RULE11] address then data, repeating
                if (!i_exp_data_reg) begin
                  i_ptr_reg <= i_byte;
                end else begin
                  i2c_pair_reg <= '{addr: i_ptr_reg, data: i_byte};
                  i2c_wr_reg   <= 1'b1;
                end
                i_exp_data_reg <= ~i_exp_data_reg;
                i_state_reg    <= I_ACK;
              end
            end
          end
          I_TX: begin
            if (scl_fall) begin
              if (i_cnt_reg == 4'h8) begin
                sda_oe      <= 1'b0;
                i_state_reg <= I_MACK;
              end else begin
                sda_oe    <= ~i_sh_reg[6];
                i_sh_reg  <= {i_sh_reg[6:0], 1'b0};
                i_cnt_reg <= i_cnt_reg + 4'h1;
              end
            end
          end
          I_MACK: begin
            if (scl_rise) begin
              // [RULE12] nack ends, ack advances, pointer sticks at end
              if (sda_sync[1]) begin
                i_state_reg <= I_IDLE;
              end else begin
                if (i_ptr_reg != ADDR_LAST)
                  i_ptr_reg <= i_ptr_reg + 8'h01;
                i_ack_on_reg <= 1'b1;
                i_state_reg  <= I_ACK;
              end
            end
          end
          default: i_state_reg <= I_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // link domain on sck; frame state cleared by chip select high
  shp_cfg_t   cfg_s1, cfg_s2;
  logic [2:0] s_cnt_reg;
  logic [7:0] s_sh_reg;
  logic       s_ctl_reg;
  logic       s_rd_reg;
  logic [6:0] s_addr_reg;
  logic [7:0] s_tx_reg;
  logic [7:0] s_byte;
  logic [7:0] s_rd_data;

  assign s_byte = {s_sh_reg[6:0], sdi_in};
  // [RULE18] spi address maps onto the i2c page
  assign s_rd_data = rd_mux({SPI_PAGE_BIT, s_addr_reg}, cfg_s2);

  // configuration snapshot brought over as levels
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      cfg_s1 <= '0;
      cfg_s2 <= '0;
    end else begin
      cfg_s1 <= cfg_m;
      cfg_s2 <= cfg_s1;
    end
  end

  // [RULE13] [RULE15] spi receive, control byte then payload
  always_ff @(posedge sck or posedge csb_n or negedge rst_n) begin
    if (!rst_n) begin
      s_cnt_reg  <= 3'h0;
      s_sh_reg   <= 8'h00;
      s_ctl_reg  <= 1'b0;
      s_rd_reg   <= 1'b0;
      s_addr_reg <= 7'h00;
    end else if (csb_n) begin
      s_cnt_reg  <= 3'h0;
      s_sh_reg   <= 8'h00;
      s_ctl_reg  <= 1'b0;
      s_rd_reg   <= 1'b0;
      s_addr_reg <= 7'h00;
    end else begin
      s_sh_reg  <= s_byte;
      s_cnt_reg <= s_cnt_reg + 3'h1;
      if (s_cnt_reg == 3'h7) begin
        if (!s_ctl_reg) begin
          s_ctl_reg  <= 1'b1;
          s_rd_reg   <= s_byte[7];
          s_addr_reg <= s_byte[6:0];
        end else if (!s_rd_reg) begin
          s_ctl_reg <= 1'b0;
        end else if (s_addr_reg != SPI_ADDR_LAST) begin
          s_addr_reg <= s_addr_reg + 7'h01;
        end
      end
    end
  end

  // [RULE13] completed write pair handed over by a toggle
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      spi_pair_reg <= '0;
      spi_tgl_reg  <= 1'b0;
    end else if (!csb_n && s_cnt_reg == 3'h7 && s_ctl_reg && !s_rd_reg) begin
      spi_pair_reg <= '{addr: {SPI_PAGE_BIT, s_addr_reg}, data: s_byte};
      spi_tgl_reg  <= ~spi_tgl_reg;
    end
  end

  // [RULE14] [RULE17] read data out on the falling edge, pin by mode
  always_ff @(negedge sck or posedge csb_n or negedge rst_n) begin
    if (!rst_n) begin
      s_tx_reg <= 8'h00;
      sdo_out  <= 1'b0;
      sdi_out  <= 1'b0;
      sdo_oe   <= 1'b0;
      sdi_oe   <= 1'b0;
    end else if (csb_n) begin
      s_tx_reg <= 8'h00;
      sdo_out  <= 1'b0;
      sdi_out  <= 1'b0;
      sdo_oe   <= 1'b0;
      sdi_oe   <= 1'b0;
    end else if (s_ctl_reg && s_rd_reg) begin
      if (s_cnt_reg == 3'h0) begin
        s_tx_reg <= {s_rd_data[6:0], 1'b0};
        sdo_out  <= s_rd_data[7];
        sdi_out  <= s_rd_data[7];
      end else begin
        s_tx_reg <= {s_tx_reg[6:0], 1'b0};
        sdo_out  <= s_tx_reg[7];
        sdi_out  <= s_tx_reg[7];
      end
      sdo_oe <= ~cfg_s2.three_wire;
      sdi_oe <= cfg_s2.three_wire;
    end else begin
      sdo_oe <= 1'b0;
      sdi_oe <= 1'b0;
    end
  end

endmodule
`default_nettype wire
